// file: include/edc_pkg.sv
package edc_pkg;
   // Address and data widths of the memory
   localparam int ROW_W = 9;
   localparam int COL_W = 9;
   localparam int DQ_W = 16;
   localparam int ADDR_W = ROW_W + COL_W;
   // Clock rate
   localparam int CLK_MHZ = 40;
   localparam int CLK_PS = 25000;
   // Power-up pause in microseconds, refresh period in milliseconds
   localparam int PWRUP_US = 200;
   localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
   localparam int WAKE_REFRESHES = 8;
   localparam int REF_ROWS = 512;
   localparam int REF_PERIOD_MS = 8;
   // Longest gap between refreshes, rounded down
   localparam int REF_GAP_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
   // Strobe times in picoseconds (slower grade), turned into cycles rounded up, with one more cycle on the column strobe
   localparam int T_RP_PS = 40000;
   localparam int T_RAS_PS = 60000;
   localparam int T_RCD_PS = 20000;
   localparam int T_CAS_PS = 10000;
   localparam int T_CP_PS = 10000;
   localparam int T_CSR_PS = 10000;
   localparam int T_CHR_PS = 10000;
   localparam int T_CAC_PS = 15000;
   localparam int RP_CYC = (T_RP_PS + CLK_PS - 1) / CLK_PS;
   localparam int RAS_CYC = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
   localparam int RCD_CYC = (T_RCD_PS + CLK_PS - 1) / CLK_PS;
   localparam int CAS_CYC = (T_CAS_PS + CLK_PS - 1) / CLK_PS + 1;
   localparam int CP_CYC = (T_CP_PS + CLK_PS - 1) / CLK_PS;
   localparam int CSR_CYC = (T_CSR_PS + CLK_PS - 1) / CLK_PS;
   localparam int CHR_CYC = (T_CHR_PS + CLK_PS - 1) / CLK_PS;
   localparam int CAC_CYC = (T_CAC_PS + CLK_PS - 1) / CLK_PS;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] BE_BOTH = 2'h3;

   typedef struct packed {
      logic write;
      logic [1:0] byte_en;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] wdata;
   } edc_req_s;

   localparam int REQ_W = $bits(edc_req_s);

   typedef struct packed {
      logic ras_n;
      logic lower_byte_column_strobe_n;
      logic upper_byte_column_strobe_n;
      logic we_n;
      logic oe_n;
      logic [ROW_W-1:0] addr;
      logic [DQ_W-1:0] dq_out;
      logic [1:0] dq_oe;
   } edc_pins_s;

   typedef enum {
      ST_PWRUP, ST_REF_COL, ST_REF_ROW, ST_REF_HOLD, ST_PRECHARGE, ST_IDLE,
      ST_ROW, ST_COL, ST_CAS_LOW, ST_CAS_HIGH
   } edc_state_e;
endpackage

// file: logic/edc_fifo.sv
module edc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset
   input wire logic [WIDTH-1:0] in_data, // Write word
   input wire logic in_valid, // Write request
   output logic in_ready, // Space left
   output logic [WIDTH-1:0] out_data, // Head word
   output logic out_valid, // Head present
   input wire logic out_ready // Head taken
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } edc_fifo_s;

   edc_fifo_s st_r;
   edc_fifo_s st_nxt;
   logic push;
   logic pop;

   assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data = st_r.mem[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop)
         st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
      if (push && !pop)
         st_nxt.cnt = st_r.cnt + 1'b1;
      else if (pop && !push)
         st_nxt.cnt = st_r.cnt - 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
endmodule

// file: logic/edc_sync.sv
module edc_sync #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset
   input wire logic [WIDTH-1:0] d_in, // Pin level
   output logic [WIDTH-1:0] d_out // Synchronised level
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } edc_sync_s;

   edc_sync_s st_r;
   edc_sync_s st_nxt;

   assign d_out = st_r.s2;

   always_comb
   begin
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
endmodule

// file: logic/edc_ctrl.sv
// Functional notes
// - After power-up wait 200 us, then issue eight refresh cycles.
// - Repeat the eight-refresh wake-up whenever refresh interval was exceeded; the code reruns it only after twice the gap.
// - Pulse both strobes high at least column precharge time to start cycle.
// - Keep write enable high through a read-command hold time.
// - Output enable high with late write enable gives late write.
// - With output enable tied low, no late write or read-modify-write.
// - Write command is recognised at write enable falling edge.
// - Keep output enable high around late writes so outputs stay released.
// - Write data setup and hold around column strobe fall in early writes.
// - Page mode must meet page cycle time between column strobe edges.
// - Refresh all 512 rows every 8 ms.
module edc_ctrl #(
   parameter int PWRUP_CYCLES = edc_pkg::PWRUP_CYC,
   parameter int REF_GAP_CYCLES = edc_pkg::REF_GAP_CYC,
   parameter int FIFO_DEPTH = edc_pkg::FIFO_DEPTH
) (
   input wire logic core_clk, // Clock, 40 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic req_valid, // Request present
   output logic req_ready, // Request accepted this cycle
   input wire logic req_write, // 1 write, 0 read
   input wire logic [1:0] req_byte_en, // Bit0 low byte, bit1 high byte
   input wire logic [edc_pkg::ADDR_W-1:0] req_addr, // Row in high bits
   input wire logic [edc_pkg::DQ_W-1:0] req_wdata, // Write data
   output logic [edc_pkg::DQ_W-1:0] rd_data, // Read data
   output logic rd_valid, // Read data pulse
   output logic init_done, // Wake-up finished
   output logic ras_n, // Row strobe
   output logic lower_byte_column_strobe_n, // Column strobe bits 0-7
   output logic upper_byte_column_strobe_n, // Column strobe bits 8-15
   output logic we_n, // Write enable
   output logic oe_n, // Output enable
   output logic [edc_pkg::ROW_W-1:0] mem_addr, // Multiplexed address
   output logic [edc_pkg::DQ_W-1:0] dq_out, // Data to memory
   output logic [1:0] dq_oe, // Drive enable per byte lane
   input wire logic [edc_pkg::DQ_W-1:0] dq_in // Data from memory
);
   // Two sync stages sit between the pins and the capture, plus one cycle spare
   localparam int CAS_HOLD = edc_pkg::CAS_CYC + edc_pkg::CAC_CYC + 1;
   // Refresh starts early so an access in flight cannot push it past the gap
   localparam int REF_SLACK = 16;
   localparam int REF_START = REF_GAP_CYCLES - REF_SLACK;
   // Twice the gap with no refresh means the cells may have lost charge
   localparam int REF_LOST = 2 * REF_GAP_CYCLES;
   localparam int LANES = 2;
   localparam int LANE_W = edc_pkg::DQ_W / LANES;

   localparam edc_pkg::edc_pins_s PINS_IDLE = '{
      ras_n: 1'h1,
      lower_byte_column_strobe_n: 1'h1,
      upper_byte_column_strobe_n: 1'h1,
      we_n: 1'h1,
      oe_n: 1'h1,
      addr: '0,
      dq_out: '0,
      dq_oe: 2'h0
   };

   typedef struct packed {
      edc_pkg::edc_state_e state;
      logic [31:0] cnt;
      logic [31:0] ref_cnt;
      logic [3:0] wake_cnt;
      logic init_done;
      edc_pkg::edc_pins_s pins;
      edc_pkg::edc_req_s cur;
      logic [edc_pkg::DQ_W-1:0] rd_data;
      logic rd_valid;
   } edc_ctrl_s;

   localparam edc_ctrl_s RESET_ST = '{
      state: edc_pkg::ST_PWRUP,
      cnt: 32'h0,
      ref_cnt: 32'h0,
      wake_cnt: 4'h0,
      init_done: 1'h0,
      pins: PINS_IDLE,
      cur: '0,
      rd_data: '0,
      rd_valid: 1'h0
   };

   edc_ctrl_s st_r;
   edc_ctrl_s st_nxt;
   edc_pkg::edc_req_s req_in;
   edc_pkg::edc_req_s fifo_req;
   logic fifo_in_ready;
   logic fifo_valid;
   logic pop;
   logic [edc_pkg::DQ_W-1:0] dq_sync;
   logic [edc_pkg::DQ_W-1:0] rd_lane;

   assign req_in = '{write: req_write, byte_en: req_byte_en, addr: req_addr, wdata: req_wdata};
   // Ready comes from the queue's fill level, the one output not registered here
   assign req_ready = fifo_in_ready;
   assign rd_data = st_r.rd_data;
   assign rd_valid = st_r.rd_valid;
   assign init_done = st_r.init_done;
   assign ras_n = st_r.pins.ras_n;
   assign lower_byte_column_strobe_n = st_r.pins.lower_byte_column_strobe_n;
   assign upper_byte_column_strobe_n = st_r.pins.upper_byte_column_strobe_n;
   assign we_n = st_r.pins.we_n;
   assign oe_n = st_r.pins.oe_n;
   assign mem_addr = st_r.pins.addr;
   assign dq_out = st_r.pins.dq_out;
   assign dq_oe = st_r.pins.dq_oe;

   // Lanes left out of the request read back as zero
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      assign rd_lane[g*LANE_W +: LANE_W] = st_r.cur.byte_en[g] ? dq_sync[g*LANE_W +: LANE_W] : '0;
   end

   edc_sync #(
      .WIDTH(edc_pkg::DQ_W)
   ) u_edc_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d_in(dq_in),
      .d_out(dq_sync)
   );

   edc_fifo #(
      .WIDTH(edc_pkg::REQ_W),
      .DEPTH(FIFO_DEPTH)
   ) u_edc_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_data(req_in),
      .in_valid(req_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_req),
      .out_valid(fifo_valid),
      .out_ready(pop)
   );

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'h0;
      st_nxt.ref_cnt = st_r.ref_cnt + 32'h1;
      st_nxt.cnt = st_r.cnt + 32'h1;
      pop = 1'h0;
      case (st_r.state)
         edc_pkg::ST_PWRUP:
         begin
            // Strobes stay high for the whole pause
            if (st_r.cnt >= 32'(PWRUP_CYCLES - 1))
            begin
               st_nxt.cnt = 32'h0;
               st_nxt.wake_cnt = 4'h0;
               st_nxt.state = edc_pkg::ST_REF_COL;
            end
         end
         edc_pkg::ST_REF_COL:
         begin
            // Both column strobes fall first, so no row address is needed
            st_nxt.pins.lower_byte_column_strobe_n = 1'h0;
            st_nxt.pins.upper_byte_column_strobe_n = 1'h0;
            st_nxt.pins.we_n = 1'h1;
            st_nxt.pins.oe_n = 1'h1;
            st_nxt.pins.dq_oe = 2'h0;
            if (st_r.cnt >= 32'(edc_pkg::CSR_CYC))
            begin
               st_nxt.cnt = 32'h0;
               st_nxt.state = edc_pkg::ST_REF_ROW;
            end
         end
         edc_pkg::ST_REF_ROW:
         begin
            st_nxt.pins.ras_n = 1'h0;
            st_nxt.ref_cnt = 32'h0;
            if (st_r.cnt >= 32'(edc_pkg::CHR_CYC))
            begin
               st_nxt.pins.lower_byte_column_strobe_n = 1'h1;
               st_nxt.pins.upper_byte_column_strobe_n = 1'h1;
               st_nxt.cnt = 32'h0;
               st_nxt.state = edc_pkg::ST_REF_HOLD;
            end
         end
         edc_pkg::ST_REF_HOLD:
         begin
            // Row strobe stays low for the full refresh pulse
            if (st_r.cnt >= 32'(edc_pkg::RAS_CYC))
            begin
               st_nxt.cnt = 32'h0;
               st_nxt.state = edc_pkg::ST_PRECHARGE;
            end
         end
         edc_pkg::ST_PRECHARGE:
         begin
            // All strobes high long enough to clear the output buffer
            st_nxt.pins = PINS_IDLE;
            st_nxt.pins.addr = st_r.pins.addr;
            if (st_r.cnt >= 32'(edc_pkg::RP_CYC))
            begin
               st_nxt.cnt = 32'h0;
               if (st_r.init_done)
                  st_nxt.state = edc_pkg::ST_IDLE;
               else if (st_r.wake_cnt == 4'(edc_pkg::WAKE_REFRESHES - 1))
               begin
                  st_nxt.init_done = 1'h1;
                  st_nxt.state = edc_pkg::ST_IDLE;
               end
               else
               begin
                  st_nxt.wake_cnt = st_r.wake_cnt + 4'h1;
                  st_nxt.state = edc_pkg::ST_REF_COL;
               end
            end
         end
         edc_pkg::ST_IDLE:
         begin
            st_nxt.cnt = 32'h0;
            if (st_r.ref_cnt >= 32'(REF_LOST))
            begin
               // Refresh was starved, so the wake-up sequence runs again
               st_nxt.init_done = 1'h0;
               st_nxt.wake_cnt = 4'h0;
               st_nxt.state = edc_pkg::ST_REF_COL;
            end
            else if (st_r.ref_cnt >= 32'(REF_START))
               st_nxt.state = edc_pkg::ST_REF_COL;
            else if (fifo_valid)
            begin
               pop = 1'h1;
               st_nxt.cur = fifo_req;
               // Row half of the address settles a cycle before the row strobe
               st_nxt.pins.addr = fifo_req.addr[edc_pkg::ADDR_W-1 -: edc_pkg::ROW_W];
               st_nxt.state = edc_pkg::ST_ROW;
            end
         end
         edc_pkg::ST_ROW:
         begin
            st_nxt.pins.ras_n = 1'h0;
            st_nxt.cnt = 32'h0;
            st_nxt.state = edc_pkg::ST_COL;
         end
         edc_pkg::ST_COL:
         begin
            if (st_r.cnt >= 32'(edc_pkg::RCD_CYC - 1))
            begin
               st_nxt.pins.addr = st_r.cur.addr[edc_pkg::COL_W-1:0];
               // Write enable falls before the column strobe: early writes only
               st_nxt.pins.we_n = !st_r.cur.write;
               // Output enable stays high on writes, so data never clashes
               st_nxt.pins.oe_n = st_r.cur.write;
               st_nxt.pins.dq_out = st_r.cur.wdata;
               st_nxt.pins.dq_oe = st_r.cur.write ? st_r.cur.byte_en : 2'h0;
               st_nxt.cnt = 32'h0;
               st_nxt.state = edc_pkg::ST_CAS_LOW;
            end
         end
         edc_pkg::ST_CAS_LOW:
         begin
            // Only the lanes asked for see a column strobe
            st_nxt.pins.lower_byte_column_strobe_n = !st_r.cur.byte_en[0];
            st_nxt.pins.upper_byte_column_strobe_n = !st_r.cur.byte_en[1];
            if (st_r.cnt >= 32'(CAS_HOLD))
            begin
               if (!st_r.cur.write)
               begin
                  st_nxt.rd_data = rd_lane;
                  st_nxt.rd_valid = 1'h1;
               end
               st_nxt.pins.lower_byte_column_strobe_n = 1'h1;
               st_nxt.pins.upper_byte_column_strobe_n = 1'h1;
               st_nxt.pins.we_n = 1'h1;
               st_nxt.pins.oe_n = 1'h1;
               st_nxt.pins.dq_oe = 2'h0;
               st_nxt.cnt = 32'h0;
               st_nxt.state = edc_pkg::ST_CAS_HIGH;
            end
         end
         edc_pkg::ST_CAS_HIGH:
         begin
            // Row strobe lags the column strobes by two cycles; no page mode, so
            // every access pays a full precharge
            st_nxt.cnt = 32'h0;
            st_nxt.state = edc_pkg::ST_PRECHARGE;
         end
         default:
         begin
            st_nxt.cnt = 32'h0;
            st_nxt.state = edc_pkg::ST_PRECHARGE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= RESET_ST;
      else
         st_r <= st_nxt;
   end
endmodule

// file: test/edc_mem_model.sv
module edc_mem_model (
   input wire logic ras_n, // Row strobe
   input wire logic lo_strobe_n, // Low lane strobe
   input wire logic hi_strobe_n, // High lane strobe
   input wire logic we_n, // Write enable
   input wire logic oe_n, // Output enable
   input wire logic [8:0] a, // Address
   input wire logic [15:0] d, // Write data
   output logic [15:0] q // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] m [0:262143];
   logic [8:0] row;
   logic [17:0] ad;
   wire [15:0] v = m[ad];
   wire lo = !lo_strobe_n && !oe_n && we_n;
   wire hi = !hi_strobe_n && !oe_n && we_n;
   // Refresh with a strobe already low keeps the row
   always @(negedge ras_n) if (lo_strobe_n && hi_strobe_n) row = a;
   always @(negedge lo_strobe_n or negedge hi_strobe_n) ad = {row, a};
   // Delay lets the column latch land first
   always @(negedge lo_strobe_n or negedge we_n)
      #1 if (!we_n && !lo_strobe_n) m[ad][7:0] = d[7:0];
   always @(negedge hi_strobe_n or negedge we_n)
      #1 if (!we_n && !hi_strobe_n) m[ad][15:8] = d[15:8];
   // Released lanes show inverted data, never the last value
   assign q = {hi ? v[15:8] : ~v[15:8], lo ? v[7:0] : ~v[7:0]};
endmodule

// file: test/edc_ctrl_properties.sv
module edc_ctrl_properties (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic init_done, // Wake-up done
   input wire logic ras_n, // Row strobe
   input wire logic lower_byte_column_strobe_n, // Low strobe
   input wire logic we_n, // Write enable
   input wire logic oe_n, // Output enable
   input wire logic [1:0] dq_oe // Lane drive
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wake_quiet_a: assert property (!init_done |-> dq_oe == 2'h0 && we_n) else $error("early access");
   row_precharge_a: assert property ($rose(ras_n) |=> ras_n) else $error("short precharge");
   col_width_a: assert property ($fell(lower_byte_column_strobe_n) |=> !lower_byte_column_strobe_n) else $error("short strobe");
   late_write_a: assert property (!we_n |-> oe_n) else $error("oe low in write");
   write_row_a: assert property ($fell(we_n) |-> !ras_n) else $error("write outside row");
   read_release_a: assert property (!oe_n |-> dq_oe == 2'h0) else $error("bus clash");
   write_data_a: assert property ($fell(lower_byte_column_strobe_n) && !we_n |-> dq_oe[0]) else $error("no data");
   ras_width_a: assert property ($fell(ras_n) |=> !ras_n [*2]) else $error("short row");
endmodule
bind edc_ctrl edc_ctrl_properties u_edc_ctrl_properties (.core_clk, .rst_n, .init_done, .ras_n,
   .lower_byte_column_strobe_n, .we_n, .oe_n, .dq_oe);

// file: test/edc_ctrl_test.sv
module edc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
   logic [1:0] req_byte_en = 0, dq_oe;
   logic [17:0] req_addr = 0;
   logic [15:0] req_wdata = 0, rd_data, dq_out, q;
   logic req_ready, rd_valid, init_done, ras_n, lo_strobe_n, hi_strobe_n, we_n, oe_n;
   logic [8:0] mem_addr;
   int mismatches = 0, checks_done = 0;
   localparam logic [52:0] ROWS [6] = '{{1'h1, 2'h3, 18'h00001, 16'h1234, 16'h0},
      {1'h1, 2'h3, 18'h3FFFF, 16'hABCD, 16'h0}, {1'h1, 2'h1, 18'h00001, 16'h55EE, 16'h0},
      {1'h1, 2'h2, 18'h3FFFF, 16'h7700, 16'h0}, {1'h0, 2'h3, 18'h00001, 16'h0, 16'h12EE},
      {1'h0, 2'h3, 18'h3FFFF, 16'h0, 16'h77CD}};
   always #12.5 core_clk = ~core_clk;
   edc_ctrl #(.PWRUP_CYCLES(40), .REF_GAP_CYCLES(60)) u_edc_ctrl (.core_clk, .rst_n,
      .req_valid, .req_ready, .req_write, .req_byte_en, .req_addr, .req_wdata, .rd_data,
      .rd_valid, .init_done, .ras_n, .lower_byte_column_strobe_n(lo_strobe_n),
      .upper_byte_column_strobe_n(hi_strobe_n), .we_n, .oe_n, .mem_addr, .dq_out, .dq_oe,
      .dq_in(q));
   edc_mem_model u_edc_mem_model (.ras_n, .lo_strobe_n, .hi_strobe_n, .we_n, .oe_n, .a(mem_addr),
      .d(dq_out), .q);
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input edc_pkg::edc_req_s r, input logic [15:0] e);
      int n = 0;
      {req_write, req_byte_en, req_addr, req_wdata} <= r;
      req_valid <= 1'h1;
      do @(posedge core_clk); while (req_ready !== 1'h1 && ++n < 500);
      req_valid <= 1'h0;
      chk(16'(n < 500), 16'h1);
      n = 0;
      if (!r.write)
      begin
         do @(posedge core_clk); while (rd_valid !== 1'h1 && ++n < 500);
         chk(16'(n < 500), 16'h1);
         chk(rd_data, e);
      end
      @(posedge core_clk);
   endtask
   task automatic wake;
      int n = 0;
      do @(posedge core_clk); while (init_done !== 1'h1 && ++n < 3000);
      chk(16'(n >= 40 && n < 3000), 16'h1);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'h1;
      wake();
      foreach (ROWS[i]) acc(ROWS[i][52:16], ROWS[i][15:0]);
      // Idle long enough that refreshes must interleave
      repeat (200) @(posedge core_clk);
      rst_n <= 1'h0;
      @(posedge core_clk);
      chk({15'h0, init_done}, 16'h0);
      rst_n <= 1'h1;
      wake();
      acc({1'h0, 2'h3, 18'h00001, 16'h0}, 16'h12EE);
      give_verdict();
   end
   initial
   begin
      #500000;
      mismatches++;
      give_verdict();
   end
endmodule
